// file: csr_pkg.sv
/*
 package for the cpu system/status register block: offsets, field positions,
 reset values, struct carriers and command codes.
 assumes a single core clock domain; nothing here is clocked.
*/
`default_nettype none
package csr_pkg;

   // ==========================================
   // register addresses
   localparam logic [7:0] CSR_ADDR_IRQCTL  = 8'hE6;
   localparam logic [7:0] CSR_ADDR_FLAGS   = 8'hE7;
   localparam logic [7:0] CSR_ADDR_WPZERO  = 8'hE8;
   localparam logic [7:0] CSR_ADDR_WPONE   = 8'hE9;
   localparam logic [3:0] CSR_GROUP_D      = 4'hD;

   // ==========================================
   // reset values
   localparam logic [7:0] CSR_RST_IRQCTL   = 8'h87;
   localparam logic [7:0] CSR_RST_FLAGS    = 8'h00;
   localparam logic [7:0] CSR_RST_WPTR     = 8'h00;

   // ==========================================
   // irq control field positions
   localparam int CSR_IC_RUN   = 7;
   localparam int CSR_IC_TLP   = 6;
   localparam int CSR_IC_TLSEL = 5;
   localparam int CSR_IC_GIE   = 4;
   localparam int CSR_IC_NEST  = 3;
   localparam int CSR_IC_LVL   = 0;
   localparam int CSR_LVL_W    = 3;

   // flag field positions
   localparam int CSR_FL_C   = 7;
   localparam int CSR_FL_Z   = 6;
   localparam int CSR_FL_S   = 5;
   localparam int CSR_FL_V   = 4;
   localparam int CSR_FL_DA  = 3;
   localparam int CSR_FL_H   = 2;
   localparam int CSR_FL_RSV = 1;
   localparam int CSR_FL_DP  = 0;

   // pointer field position
   localparam int CSR_WP_MODE = 2;
   localparam logic [7:0] CSR_WP_MASK = 8'hFC;
   localparam int CSR_WP_BLK  = 3;
   localparam int CSR_BLK_W   = 5;
   localparam logic [2:0] CSR_WP_SINGLE = 3'h0;
   localparam logic [2:0] CSR_WP_TWIN   = 3'h4;

   localparam int CSR_NEST_DEPTH = 7;
   localparam logic [2:0] CSR_LVL_LOWEST = 3'h7;

   // ==========================================
   // core commands that touch the system registers
   typedef enum logic [3:0]
   {
      CSR_CMD_NONE  = 4'b0000,
      CSR_CMD_EI    = 4'b0001,
      CSR_CMD_DI    = 4'b0010,
      CSR_CMD_IRET  = 4'b0011,
      CSR_CMD_SCF   = 4'b0100,
      CSR_CMD_RCF   = 4'b0101,
      CSR_CMD_CCF   = 4'b0110,
      CSR_CMD_SDM   = 4'b0111,
      CSR_CMD_SPM   = 4'b1000,
      CSR_CMD_SRP   = 4'b1001,
      CSR_CMD_SET_LOW_POINTER  = 4'b1010,
      CSR_CMD_SET_HIGH_POINTER  = 4'b1011
   } csr_cmd_e;

   // alu result for flag update
   typedef struct packed
   {
      logic        valid;
      logic        isWord;
      logic        isSub;
      logic [15:0] result;
      logic        carryOut;
      logic        overflow;
      logic        halfCarry;
      logic        writeCarry;
      logic        writeHalf;
   } csr_alu_s;

   // register file access from the core
   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic       direct;
      logic [7:0] addr;
      logic [7:0] data;
   } csr_reg_s;

   // interrupt controller events
   typedef struct packed
   {
      logic       topReq;
      logic       ack;
      logic       preempt;
      logic [2:0] newLevel;
   } csr_irq_s;

endpackage
`default_nettype wire

// file: csr_flag_stack.sv
/*
 flag save stack: holds the flag copies pushed on interrupt entry.
 assumes the core pushes on acknowledge and pops on interrupt return.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_flag_stack
   import csr_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       push,
   input  wire logic       pop,
   input  wire logic [7:0] pushData,
   output logic      [7:0] topData,
   output logic            empty
);

   // ==========================================
   // storage
   logic [7:0] slot_r [CSR_NEST_DEPTH];
   logic [2:0] depth_r;
   logic [2:0] depth_nxt;
   logic       doPush;
   logic       doPop;

   assign doPush    = push && (depth_r != 3'(CSR_NEST_DEPTH));
   assign doPop     = pop && (depth_r != 3'h0);
   assign depth_nxt = doPush ? depth_r + 3'h1 : (doPop ? depth_r - 3'h1 : depth_r);
   assign empty     = (depth_r == 3'h0);
   assign topData   = empty ? CSR_RST_FLAGS : slot_r[depth_r - 3'h1];

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         depth_r <= 3'h0;
      else
         depth_r <= depth_nxt;
   end

   // slots carry no reset; depth alone defines what is valid
   genvar g;
   generate
      for (g = 0; g < CSR_NEST_DEPTH; g++)
      begin : gSlot
         always_ff @(posedge clk_sys)
         begin
            if (doPush && (depth_r == 3'(g)))
               slot_r[g] <= pushData;
         end
      end
   endgenerate

endmodule
`default_nettype wire

// file: csr_reg_map.sv
/*
 working register address mapping: turns rN references into register file
 addresses from the two pointers, and flags illegal direct access to group d.
 assumes pointer values with reserved bits already zero.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_reg_map
   import csr_pkg::*;
(
   input  wire logic [7:0] wpZero,
   input  wire logic [7:0] wpOne,
   input  wire logic [3:0] workIdx,
   input  wire logic [7:0] directAddr,
   output logic      [7:0] workAddr,
   output logic            directIllegal
);

   // ==========================================
   // block selection
   logic       twinMode;
   logic [4:0] blkZero;
   logic [4:0] blkOne;
   logic [4:0] blkSingle;
   logic [4:0] blkSel;

   assign twinMode  = wpZero[CSR_WP_MODE];
   assign blkZero   = wpZero[CSR_WP_BLK +: CSR_BLK_W];
   assign blkOne    = wpOne[CSR_WP_BLK +: CSR_BLK_W];
   assign blkSingle = {blkZero[4:1], 1'b0};
   assign blkSel    = twinMode ? (workIdx[3] ? blkOne : blkZero)
                               : (blkSingle | {4'h0, workIdx[3]});
   assign workAddr  = {blkSel, workIdx[2:0]};
   assign directIllegal = (directAddr[7:4] == CSR_GROUP_D);

endmodule
`default_nettype wire

// file: csr_sys_regs.sv
/*
 cpu system register block: interrupt control, condition flags and the two
 working register pointers, with flag save stack and working address map.
 assumes the core presents one register access and one command per cycle.
*/
// Operation
// - timer runs when global and local enables set
// - top-level pending set by hardware or write-one
// - masking select chooses mask-only or enable-plus-mask
// - enable clears on acknowledge, sets on return
// - disabled blocks all sources; top-level too when enable-plus-mask selected
// - arbitration mode bit is software written only
// - current level 0 highest, 7 lowest, compared
// - preempted level saved in nested save register
// - flags pushed on interrupt, restored on return
// - carry from top bit; set, clear, invert
// - zero flag set on zero result
// - sign flag equals result top bit
// - overflow flag marks two's-complement range error
// - adjust-kind flag records add or subtract
// - half carry captures bit 3 carry/borrow
// - flag bit 1 reserved, held zero
// - memory-space flag set/cleared by instructions
// - 32 blocks; single and twin pointer modes
// - single mode rounds block down to even
// - twin mode maps low and high halves
// - group d never directly addressable
// - pointer holds block, mode bit, zero bits
`timescale 1ns/1ps
`default_nettype none
module csr_sys_regs
   import csr_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire csr_reg_s   regBus,
   input  wire csr_cmd_e   cmd,
   input  wire logic [7:0] cmdArg,
   input  wire csr_alu_s   alu,
   input  wire csr_irq_s   irqIn,
   input  wire logic       topMaskBit,
   input  wire logic       timerLocalRun,
   input  wire logic       srcReq,
   input  wire logic [2:0] srcLevel,
   input  wire logic [3:0] workIdx,
   output logic      [7:0] regRdata,
   output logic            regErr,
   output logic            timerRun,
   output logic            topAckOk,
   output logic            srcAccept,
   output logic            srcPreempt,
   output logic      [2:0] nestSave,
   output logic            dataSpace,
   output logic      [7:0] workAddr,
   output logic      [7:0] irqCtlOut,
   output logic      [7:0] flagsOut
);

   // ==========================================
   // state
   logic [7:0] irqCtl_r;
   logic [7:0] irqCtl_nxt;
   logic [7:0] flags_r;
   logic [7:0] flags_nxt;
   logic [7:0] wpZero_r;
   logic [7:0] wpZero_nxt;
   logic [7:0] wpOne_r;
   logic [7:0] wpOne_nxt;
   logic [2:0] nestSave_r;
   logic [2:0] nestSave_nxt;
   logic [7:0] regRdata_r;
   logic       regErr_r;
   logic       timerRun_r;
   logic       topAckOk_r;
   logic       srcAccept_r;
   logic       srcPreempt_r;
   logic [7:0] workAddr_r;

   // ==========================================
   // decode
   logic wrIrq;
   logic wrFlags;
   logic wrWp0;
   logic wrWp1;
   logic directIllegal;
   logic [7:0] mapAddr;
   logic [7:0] stackTop;
   logic       stackEmpty;
   logic       isIret;
   logic [2:0] curLevel;
   logic [4:0] argBlock;

   assign wrIrq   = regBus.wr && (regBus.addr == CSR_ADDR_IRQCTL) && !directIllegal;
   assign wrFlags = regBus.wr && (regBus.addr == CSR_ADDR_FLAGS) && !directIllegal;
   assign wrWp0   = regBus.wr && (regBus.addr == CSR_ADDR_WPZERO);
   assign wrWp1   = regBus.wr && (regBus.addr == CSR_ADDR_WPONE);
   assign isIret  = (cmd == CSR_CMD_IRET);
   assign curLevel = irqCtl_r[CSR_IC_LVL +: CSR_LVL_W];
   assign argBlock = cmdArg[CSR_WP_BLK +: CSR_BLK_W];

   // ==========================================
   // interrupt control next value
   // software write first, then hardware events so a set is never lost
   logic [7:0] icSw;
   logic       tlpNxt;

   assign icSw = wrIrq ? regBus.data : irqCtl_r;

   // a direct write of the enable is not guarded; software must quiet requests first

   always_comb
   begin
      irqCtl_nxt = icSw;
      // pending bit: write of one sets, hardware recognition sets, write zero clears
      tlpNxt = wrIrq ? (regBus.data[CSR_IC_TLP] | irqCtl_r[CSR_IC_TLP])
                     : irqCtl_r[CSR_IC_TLP];
      if (wrIrq && !regBus.data[CSR_IC_TLP])
         tlpNxt = 1'b0;
      irqCtl_nxt[CSR_IC_TLP] = tlpNxt | irqIn.topReq;
      if (cmd == CSR_CMD_EI)
         irqCtl_nxt[CSR_IC_GIE] = 1'b1;
      else if (cmd == CSR_CMD_DI)
         irqCtl_nxt[CSR_IC_GIE] = 1'b0;
      if (isIret)
         irqCtl_nxt[CSR_IC_GIE] = 1'b1;
      if (irqIn.ack)
         irqCtl_nxt[CSR_IC_GIE] = 1'b0;
      if (irqIn.ack || irqIn.preempt)
         irqCtl_nxt[CSR_IC_LVL +: CSR_LVL_W] = irqIn.newLevel;
      else if (isIret && irqCtl_r[CSR_IC_NEST])
         irqCtl_nxt[CSR_IC_LVL +: CSR_LVL_W] = nestSave_r;
   end

   // nesting mode bit only moves through icSw, i.e. by software
   assign nestSave_nxt = irqIn.preempt ? curLevel : nestSave_r;

   // ==========================================
   // flag next value
   logic [15:0] res;
   logic        resZero;
   logic        resSign;

   assign res     = alu.isWord ? alu.result : {8'h00, alu.result[7:0]};
   assign resZero = (res == 16'h0000);
   assign resSign = alu.isWord ? alu.result[15] : alu.result[7];

   always_comb
   begin
      flags_nxt = wrFlags ? regBus.data : flags_r;
      if (alu.valid)
      begin
         flags_nxt[CSR_FL_Z] = resZero;
         flags_nxt[CSR_FL_S] = resSign;
         flags_nxt[CSR_FL_V] = alu.overflow;
         if (alu.writeCarry)
            flags_nxt[CSR_FL_C] = alu.carryOut;
         if (alu.writeHalf)
         begin
            flags_nxt[CSR_FL_H]  = alu.halfCarry;
            flags_nxt[CSR_FL_DA] = alu.isSub;
         end
      end
      unique case (cmd)
         CSR_CMD_SCF: flags_nxt[CSR_FL_C] = 1'b1;
         CSR_CMD_RCF: flags_nxt[CSR_FL_C] = 1'b0;
         CSR_CMD_CCF: flags_nxt[CSR_FL_C] = !flags_r[CSR_FL_C];
         CSR_CMD_SDM: flags_nxt[CSR_FL_DP] = 1'b1;
         CSR_CMD_SPM: flags_nxt[CSR_FL_DP] = 1'b0;
         default: ;
      endcase
      if (isIret && !stackEmpty)
         flags_nxt = stackTop;
      flags_nxt[CSR_FL_RSV] = 1'b0;
   end

   // ==========================================
   // pointer next values
   always_comb
   begin
      wpZero_nxt = wrWp0 ? regBus.data : wpZero_r;
      wpOne_nxt  = wrWp1 ? regBus.data : wpOne_r;
      unique case (cmd)
         CSR_CMD_SRP:
         begin
            wpZero_nxt = {argBlock, CSR_WP_SINGLE};
            wpOne_nxt[CSR_WP_MODE] = 1'b0;
         end
         CSR_CMD_SET_LOW_POINTER:
         begin
            wpZero_nxt = {argBlock, CSR_WP_TWIN};
            wpOne_nxt[CSR_WP_MODE] = 1'b1;
         end
         CSR_CMD_SET_HIGH_POINTER:
         begin
            wpOne_nxt = {argBlock, CSR_WP_TWIN};
            wpZero_nxt[CSR_WP_MODE] = 1'b1;
         end
         default: ;
      endcase
      wpZero_nxt = wpZero_nxt & CSR_WP_MASK;
      wpOne_nxt  = wpOne_nxt & CSR_WP_MASK;
   end

   // ==========================================
   // arbitration outputs
   logic topOkNxt;
   logic acceptNxt;
   logic preemptNxt;
   logic runNxt;
   logic errNxt;
   logic readSel;
   logic [7:0] readMux;

   assign topOkNxt = irqCtl_r[CSR_IC_TLSEL] ? (irqCtl_r[CSR_IC_GIE] && topMaskBit)
                                            : topMaskBit;
   assign acceptNxt  = srcReq && irqCtl_r[CSR_IC_GIE];
   assign preemptNxt = acceptNxt && (srcLevel < curLevel);
   assign runNxt     = irqCtl_r[CSR_IC_RUN] && timerLocalRun;
   assign errNxt     = (regBus.rd || regBus.wr) && regBus.direct && directIllegal;
   assign readSel    = regBus.rd;
   assign readMux    = (regBus.addr == CSR_ADDR_IRQCTL) ? irqCtl_r :
                       (regBus.addr == CSR_ADDR_FLAGS)  ? flags_r  :
                       (regBus.addr == CSR_ADDR_WPZERO) ? wpZero_r :
                       (regBus.addr == CSR_ADDR_WPONE)  ? wpOne_r  : 8'h00;

   // ==========================================
   // registers
   // architectural state, split by function so each block stays short
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         irqCtl_r   <= CSR_RST_IRQCTL;
         nestSave_r <= CSR_LVL_LOWEST;
      end
      else
      begin
         irqCtl_r   <= irqCtl_nxt;
         nestSave_r <= nestSave_nxt;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         flags_r <= CSR_RST_FLAGS;
      else
         flags_r <= flags_nxt;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         wpZero_r <= CSR_RST_WPTR;
         wpOne_r  <= CSR_RST_WPTR;
      end
      else
      begin
         wpZero_r <= wpZero_nxt;
         wpOne_r  <= wpOne_nxt;
      end
   end

   // ==========================================
   // registered outputs
   // the core sees every result one cycle after its request
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         regRdata_r <= 8'h00;
         regErr_r   <= 1'b0;
      end
      else
      begin
         regRdata_r <= readSel ? readMux : 8'h00;
         regErr_r   <= errNxt;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         timerRun_r   <= 1'b0;
         topAckOk_r   <= 1'b0;
         srcAccept_r  <= 1'b0;
         srcPreempt_r <= 1'b0;
      end
      else
      begin
         timerRun_r   <= runNxt;
         topAckOk_r   <= topOkNxt;
         srcAccept_r  <= acceptNxt;
         srcPreempt_r <= preemptNxt;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         workAddr_r <= 8'h00;
      else
         workAddr_r <= mapAddr;
   end

   // ==========================================
   // outputs
   assign regRdata   = regRdata_r;
   assign regErr     = regErr_r;
   assign timerRun   = timerRun_r;
   assign topAckOk   = topAckOk_r;
   assign srcAccept  = srcAccept_r;
   assign srcPreempt = srcPreempt_r;
   assign nestSave   = nestSave_r;
   assign dataSpace  = flags_r[CSR_FL_DP];
   assign workAddr   = workAddr_r;
   assign irqCtlOut  = irqCtl_r;
   assign flagsOut   = flags_r;

   // ==========================================
   // submodules
   // an ack in the same cycle as iret wins unless the stack is full: it pushes and the pop is dropped
   csr_flag_stack uFlagStack
   (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .push     (irqIn.ack),
      .pop      (isIret),
      .pushData (flags_r),
      .topData  (stackTop),
      .empty    (stackEmpty)
   );

   csr_reg_map uRegMap
   (
      .wpZero        (wpZero_r),
      .wpOne         (wpOne_r),
      .workIdx       (workIdx),
      .directAddr    (regBus.addr),
      .workAddr      (mapAddr),
      .directIllegal (directIllegal)
   );

endmodule
`default_nettype wire

// file: csr_sys_regs_properties.sv
/*
 concurrent checks on the system register block, seen from its ports only.
 assumes one core clock and the synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_sys_regs_props
   import csr_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       reset,
   input wire csr_reg_s   regBus,
   input wire csr_cmd_e   cmd,
   input wire csr_alu_s   alu,
   input wire csr_irq_s   irqIn,
   input wire logic       timerLocalRun,
   input wire logic       srcReq,
   input wire logic       regErr,
   input wire logic       timerRun,
   input wire logic       srcAccept,
   input wire logic [7:0] irqCtlOut,
   input wire logic [7:0] flagsOut
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // ==========================================
   // helpers
   wire dirD    = regBus.direct && (regBus.wr || regBus.rd) && regBus.addr[7:4] == CSR_GROUP_D;
   wire quiet   = !alu.valid && !regBus.wr;
   wire aluOnly = alu.valid && cmd == CSR_CMD_NONE && !regBus.wr;
   wire zeroRes = alu.isWord ? (alu.result == 16'h0000) : (alu.result[7:0] == 8'h00);
   wire signRes = alu.isWord ? alu.result[15] : alu.result[7];

   // ==========================================
   // properties
   a_timer_and_gate: assert property (1'b1 |=> timerRun ==
      ($past(irqCtlOut[CSR_IC_RUN]) && $past(timerLocalRun))) else $error("timer gate wrong");
   a_top_pending_set: assert property (irqIn.topReq |=> irqCtlOut[CSR_IC_TLP])
      else $error("pending not set");
   a_ack_clears_gie: assert property (irqIn.ack |=> !irqCtlOut[CSR_IC_GIE])
      else $error("enable kept on ack");
   a_iret_sets_gie: assert property (cmd == CSR_CMD_IRET && !irqIn.ack
      |=> irqCtlOut[CSR_IC_GIE]) else $error("enable not set on return");
   a_src_accept_gie: assert property ($stable(irqCtlOut[CSR_IC_GIE]) |->
      srcAccept == ($past(srcReq) && irqCtlOut[CSR_IC_GIE])) else $error("accept wrong");
   a_flag_rsv_zero: assert property (flagsOut[CSR_FL_RSV] == 1'b0)
      else $error("reserved flag set");
   a_scf_sets_carry: assert property (cmd == CSR_CMD_SCF && quiet |=> flagsOut[CSR_FL_C])
      else $error("carry not set");
   a_ccf_flips_carry: assert property (cmd == CSR_CMD_CCF && quiet |=>
      flagsOut[CSR_FL_C] != $past(flagsOut[CSR_FL_C])) else $error("carry not inverted");
   a_sdm_sets_space: assert property (cmd == CSR_CMD_SDM && !regBus.wr
      |=> flagsOut[CSR_FL_DP]) else $error("space flag not set");
   a_zero_sign_res: assert property (aluOnly |=> flagsOut[CSR_FL_Z] == $past(zeroRes)
      && flagsOut[CSR_FL_S] == $past(signRes)) else $error("zero or sign wrong");
   a_regerr_direct: assert property (1'b1 |=> regErr == $past(dirD))
      else $error("direct access flag wrong");
endmodule

bind csr_sys_regs csr_sys_regs_props csr_sys_regs_props_inst
(
   .clk_sys       (clk_sys),
   .reset         (reset),
   .regBus        (regBus),
   .cmd           (cmd),
   .alu           (alu),
   .irqIn         (irqIn),
   .timerLocalRun (timerLocalRun),
   .srcReq        (srcReq),
   .regErr        (regErr),
   .timerRun      (timerRun),
   .srcAccept     (srcAccept),
   .irqCtlOut     (irqCtlOut),
   .flagsOut      (flagsOut)
);
`default_nettype wire

// file: test_csr_sys_regs.sv
/*
 self-checking bench for the system register block: register reads and
 writes, core commands, interrupt events and alu flag updates.
 assumes the block answers one cycle after each request.
*/
`timescale 1ns/1ps
`default_nettype none
module test_csr_sys_regs
   import csr_pkg::*;
;
   logic       clk_sys, reset, topMaskBit, timerLocalRun, srcReq;
   logic       regErr, timerRun, topAckOk, srcAccept, srcPreempt, dataSpace;
   csr_reg_s   bus;
   csr_cmd_e   cmd;
   csr_alu_s   alu;
   csr_irq_s   irq;
   logic [7:0] cmdArg, regRdata, workAddr, irqCtlOut, flagsOut;
   logic [2:0] srcLevel, nestSave;
   logic [3:0] workIdx;
   int         failCount = 0;
   int         compares = 0;

   csr_sys_regs csr_sys_regs_inst
   (
      .clk_sys(clk_sys), .reset(reset), .regBus(bus), .cmd(cmd), .cmdArg(cmdArg),
      .alu(alu), .irqIn(irq), .topMaskBit(topMaskBit), .timerLocalRun(timerLocalRun),
      .srcReq(srcReq), .srcLevel(srcLevel), .workIdx(workIdx), .regRdata(regRdata),
      .regErr(regErr), .timerRun(timerRun), .topAckOk(topAckOk), .srcAccept(srcAccept),
      .srcPreempt(srcPreempt), .nestSave(nestSave), .dataSpace(dataSpace),
      .workAddr(workAddr), .irqCtlOut(irqCtlOut), .flagsOut(flagsOut)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // ==========================================
   // access tasks
   // each request lets one edge pass first, so no strobe is rewritten in one time step
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         failCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         failCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dir = 1'b1);
      tick();
      bus = '{wr:1'b1, rd:1'b0, direct:dir, addr:a, data:d};
      tick();
      bus.wr = 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      tick();
      bus = '{wr:1'b0, rd:1'b1, direct:1'b1, addr:a, data:8'h00};
      tick();
      bus.rd = 1'b0;
      chk8(regRdata, exp);
   endtask
   task automatic op(input csr_cmd_e c, input logic [7:0] a = 8'h00);
      tick();
      cmd = c;
      cmdArg = a;
      tick();
      cmd = CSR_CMD_NONE;
   endtask
   task automatic irqp(input logic t, input logic k, input logic p, input logic [2:0] l);
      tick();
      irq = '{t, k, p, l};
      tick();
      irq = '0;
   endtask
   // writeCarry always on; writeHalf chosen per operation
   task automatic aluOp(input logic w, input logic s, input logic [15:0] r,
                        input logic c, input logic v, input logic h, input logic wh);
      tick();
      alu = '{1'b1, w, s, r, c, v, h, 1'b1, wh};
      tick();
      alu.valid = 1'b0;
   endtask
   task automatic wa(input logic [3:0] i, input logic [7:0] exp);
      workIdx = i;
      tick(2);
      chk8(workAddr, exp);
   endtask
   task automatic results;
      $display("compares=%0d failCount=%0d", compares, failCount);
      if (failCount == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ==========================================
   // main sequence
   initial
   begin
      reset = 1'b1; bus = '0; cmd = CSR_CMD_NONE; cmdArg = 8'h00; alu = '0; irq = '0;
      topMaskBit = 1'b0; timerLocalRun = 1'b0; srcReq = 1'b0; srcLevel = 3'h0; workIdx = 4'h0;
      tick(20);
      reset = 1'b0;
      rdc(CSR_ADDR_IRQCTL, 8'h87);
      rdc(CSR_ADDR_FLAGS, 8'h00);
      rdc(CSR_ADDR_WPZERO, 8'h00);
      rdc(CSR_ADDR_WPONE, 8'h00);
      rdc(8'hD0, 8'h00);
      chk1(regErr, 1'b1);
      chk8({5'h00, nestSave}, 8'h07);
      timerLocalRun = 1'b1;
      tick(2);
      chk1(timerRun, 1'b1);
      wr(CSR_ADDR_IRQCTL, 8'h07);
      tick();
      chk1(timerRun, 1'b0);
      wr(CSR_ADDR_IRQCTL, 8'hC7);
      chk8(irqCtlOut, 8'hC7);
      wr(CSR_ADDR_IRQCTL, 8'h87);
      chk8(irqCtlOut, 8'h87);
      // hardware set must win over a software clear in the same cycle
      irq.topReq = 1'b1;
      wr(CSR_ADDR_IRQCTL, 8'h87);
      irq = '0;
      chk1(irqCtlOut[CSR_IC_TLP], 1'b1);
      wr(CSR_ADDR_IRQCTL, 8'hA7);
      topMaskBit = 1'b1;
      tick(2);
      chk1(topAckOk, 1'b0);
      wr(CSR_ADDR_IRQCTL, 8'h87);
      tick(2);
      chk1(topAckOk, 1'b1);
      topMaskBit = 1'b0;
      tick(2);
      chk1(topAckOk, 1'b0);
      op(CSR_CMD_EI);
      chk1(irqCtlOut[CSR_IC_GIE], 1'b1);
      srcReq = 1'b1;
      srcLevel = 3'h3;
      tick();
      chk1(srcAccept, 1'b1);
      chk1(srcPreempt, 1'b1);
      srcLevel = 3'h7;
      tick();
      chk1(srcPreempt, 1'b0);
      op(CSR_CMD_DI);
      tick();
      chk1(srcAccept, 1'b0);
      srcReq = 1'b0;
      // nested mode, level 7, enabled; carry set before entry
      wr(CSR_ADDR_IRQCTL, 8'h9F);
      op(CSR_CMD_SCF);
      irqp(1'b0, 1'b1, 1'b0, 3'h3);
      chk8(irqCtlOut, 8'h8B);
      irqp(1'b0, 1'b0, 1'b1, 3'h3);
      chk8({5'h00, nestSave}, 8'h03);
      irqp(1'b0, 1'b1, 1'b0, 3'h1);
      op(CSR_CMD_RCF);
      chk8(flagsOut, 8'h00);
      op(CSR_CMD_IRET);
      chk8(irqCtlOut, 8'h9B);
      chk8(flagsOut, 8'h80);
      wr(CSR_ADDR_FLAGS, 8'h00);
      aluOp(1'b0, 1'b0, 16'h5500, 1'b1, 1'b0, 1'b1, 1'b1);
      chk8(flagsOut, 8'hC4);
      aluOp(1'b1, 1'b1, 16'h8000, 1'b0, 1'b1, 1'b0, 1'b1);
      chk8(flagsOut, 8'h38);
      aluOp(1'b1, 1'b0, 16'h0080, 1'b0, 1'b0, 1'b1, 1'b0);
      chk8(flagsOut, 8'h08);
      op(CSR_CMD_SCF);
      chk8(flagsOut, 8'h88);
      op(CSR_CMD_CCF);
      chk8(flagsOut, 8'h08);
      wr(CSR_ADDR_FLAGS, 8'hFF);
      rdc(CSR_ADDR_FLAGS, 8'hFD);
      chk1(dataSpace, 1'b1);
      op(CSR_CMD_SPM);
      chk8(flagsOut, 8'hFC);
      op(CSR_CMD_SDM);
      chk8(flagsOut, 8'hFD);
      op(CSR_CMD_SRP, 8'h18);
      rdc(CSR_ADDR_WPZERO, 8'h18);
      wa(4'h0, 8'h10);
      wa(4'h9, 8'h19);
      op(CSR_CMD_SET_LOW_POINTER, 8'h28);
      op(CSR_CMD_SET_HIGH_POINTER, 8'hD0);
      rdc(CSR_ADDR_WPZERO, 8'h2C);
      rdc(CSR_ADDR_WPONE, 8'hD4);
      wa(4'h2, 8'h2A);
      wa(4'hB, 8'hD3);
      wr(CSR_ADDR_WPZERO, 8'hFF);
      rdc(CSR_ADDR_WPZERO, 8'hFC);
      wr(8'hD5, 8'h55, 1'b1);
      chk1(regErr, 1'b1);
      wr(8'hD5, 8'h55, 1'b0);
      chk1(regErr, 1'b0);
      // concurrent mode: return keeps the level set on entry
      wr(CSR_ADDR_IRQCTL, 8'h95);
      irqp(1'b0, 1'b1, 1'b0, 3'h2);
      op(CSR_CMD_IRET);
      chk8(irqCtlOut, 8'h92);
      results();
   end
endmodule
`default_nettype wire
